//--- rtl/fcsu_core.sv
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "fcsu_map.svh"

module fcsu_core (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic                      array_start,
    output fcsu_pkg::fcsu_req_type    array_req,
    output logic                      array_abort,
    input  wire logic                 array_done,
    input  wire logic                 array_blank_ok,
    output logic [15:0]               staged_addr,
    input  wire logic                 target_protected,
    input  wire logic                 any_sector_protected,
    input  wire logic                 stop_mode
);
    import fcsu_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic         aw_full_q;
    logic         w_full_q;
    logic [7:0]   awaddr_q;
    logic [31:0]  wdata_q;
    logic [3:0]   wstrb_q;
    logic         awready_q;
    logic         wready_q;
    logic         bvalid_q;
    logic [1:0]   bresp_q;
    logic         arready_q;
    logic         rvalid_q;
    logic [31:0]  rdata_q;
    logic [1:0]   rresp_q;

    fcsu_eng_type eng_q;
    fcsu_eng_type eng_d;
    fcsu_seq_type seq_q;
    logic         cbef_q;
    logic         ccf_q;
    logic         pviol_q;
    logic         acc_q;
    logic         blank_q;
    logic [7:0]   div_q;
    logic         div_loaded_q;
    logic [7:0]   code_q;
    logic [15:0]  addr_q;
    logic [7:0]   data_q;
    logic [7:0]   run_code_q;
    fcsu_req_type pend_q;
    fcsu_req_type req_q;
    logic         start_q;
    logic         abort_q;
    logic         stop_q;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire aw_take  = s_axi_awvalid & awready_q;
    wire w_take   = s_axi_wvalid & wready_q;
    wire wr_fire  = aw_full_q & w_full_q & ~bvalid_q;
    wire b_done   = bvalid_q & s_axi_bready;
    wire ar_take  = s_axi_arvalid & arready_q;
    wire r_done   = rvalid_q & s_axi_rready;

    wire [7:0] wa = {awaddr_q[7:2], 2'b00};
    wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};

    wire sel_w_status = (wa == `FCSU_OFF_STATUS);
    wire sel_w_cmd    = (wa == `FCSU_OFF_CMD);
    wire sel_w_div    = (wa == `FCSU_OFF_DIVIDER);
    wire sel_w_addr   = (wa == `FCSU_OFF_ADDR);
    wire sel_w_data   = (wa == `FCSU_OFF_DATA);
    wire w_mapped     = sel_w_status | sel_w_cmd | sel_w_div | sel_w_addr | sel_w_data;

    wire sel_r_status = (ra == `FCSU_OFF_STATUS);
    wire sel_r_cmd    = (ra == `FCSU_OFF_CMD);
    wire sel_r_div    = (ra == `FCSU_OFF_DIVIDER);
    wire sel_r_addr   = (ra == `FCSU_OFF_ADDR);
    wire sel_r_data   = (ra == `FCSU_OFF_DATA);
    wire r_mapped     = sel_r_status | sel_r_cmd | sel_r_div | sel_r_addr | sel_r_data;

    wire [7:0] w_lo   = wdata_q[7:0];
    wire       lane0  = wstrb_q[0];
    wire wr_status    = wr_fire & sel_w_status & lane0;
    wire wr_cmd       = wr_fire & sel_w_cmd & lane0;
    wire wr_div       = wr_fire & sel_w_div & lane0;
    wire wr_addr_lo   = wr_fire & sel_w_addr & lane0;
    wire wr_addr_hi   = wr_fire & sel_w_addr & wstrb_q[1];
    wire wr_data      = wr_fire & sel_w_data & lane0;

    // ----------------------------------------------------------------
    // command checks
    // ----------------------------------------------------------------
    wire is_blank  = (code_q == `FCSU_CMD_BLANK);
    wire is_byte   = (code_q == `FCSU_CMD_BYTE);
    wire is_burst  = (code_q == `FCSU_CMD_BURST);
    wire is_sector = (code_q == `FCSU_CMD_SECTOR);
    wire is_mass   = (code_q == `FCSU_CMD_MASS);
    wire is_abort  = (code_q == `FCSU_CMD_ABORT);
    wire cmd_legal = is_blank | is_byte | is_burst | is_sector | is_mass | is_abort;

    wire busy      = (eng_q != FCSU_IDLE);
    wire run_burst = (run_code_q == `FCSU_CMD_BURST);
    wire run_erase = (run_code_q == `FCSU_CMD_SECTOR);
    wire done_run  = array_done & (eng_q == FCSU_RUN);
    wire done_pend = array_done & (eng_q == FCSU_RUN_Q);

    // a write-one to the launch bit only counts while the buffer has room
    wire launch    = wr_status & w_lo[`FCSU_BIT_CBEF] & cbef_q;
    wire bad_code  = ~cmd_legal;
    wire bad_seq   = (seq_q != FCSU_SEQ_CMD) | pviol_q | acc_q;
    wire bad_div   = ~is_abort & ~div_loaded_q;
    // while busy only a burst behind a burst, or an abort of a sector erase, is taken
    wire bad_queue = busy & ~(is_burst & run_burst) & ~(is_abort & run_erase);
    wire bad_any   = bad_code | bad_seq | bad_div | bad_queue;
    wire prot_hit  = (is_mass & any_sector_protected)
                   | ((is_byte | is_burst | is_sector) & target_protected);

    wire launch_acc   = launch & bad_any;
    wire launch_pviol = launch & ~bad_any & prot_hit;
    wire go           = launch & ~bad_any & ~prot_hit;
    wire go_abort     = go & busy & is_abort;
    wire go_queue     = go & busy & is_burst;
    wire start_new    = (go & ~busy) | (go_queue & done_run);
    wire queue_hold   = go_queue & ~done_run;

    // register writes that break the data, command, launch order
    wire seq_acc   = (wr_data & ~cbef_q)
                   | (wr_cmd & (~cbef_q | (seq_q != FCSU_SEQ_DATA)));
    wire stop_rise = stop_mode & ~stop_q;
    wire stop_acc  = stop_rise & busy;
    wire stop_drop = stop_acc & (eng_q == FCSU_RUN_Q);
    wire acc_set   = launch_acc | seq_acc | stop_acc;

    wire clr_pviol = wr_status & w_lo[`FCSU_BIT_PVIOL];
    wire clr_acc   = wr_status & w_lo[`FCSU_BIT_ACCERR];

    wire fcsu_req_type new_req = '{code: code_q, addr: addr_q, data: data_q};

    // ----------------------------------------------------------------
    // engine state
    // ----------------------------------------------------------------
    always_comb begin
        eng_d = eng_q;
        unique case (eng_q)
            FCSU_IDLE: begin
                if (start_new) begin
                    eng_d = FCSU_RUN;
                end
            end
            FCSU_RUN: begin
                if (done_run & ~go_queue) begin
                    eng_d = FCSU_IDLE;
                end else if (queue_hold) begin
                    eng_d = FCSU_RUN_Q;
                end
            end
            FCSU_RUN_Q: begin
                if (done_pend | stop_drop) begin
                    eng_d = FCSU_RUN;
                end
            end
            default: begin
                eng_d = FCSU_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eng_q <= FCSU_IDLE;
            ccf_q <= 1'b1;
        end else begin
            eng_q <= eng_d;
            ccf_q <= (eng_d == FCSU_IDLE);
        end
    end

    // launch flag falls while a burst waits and rises when it passes on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cbef_q <= 1'b1;
        end else if (queue_hold) begin
            cbef_q <= 1'b0;
        end else if (done_pend | stop_drop) begin
            cbef_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // error and blank flags; a set in the cycle of a clear wins
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pviol_q <= 1'b0;
            acc_q   <= 1'b0;
        end else begin
            pviol_q <= launch_pviol | (pviol_q & ~clr_pviol);
            acc_q   <= acc_set | (acc_q & ~clr_acc);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blank_q <= 1'b0;
        end else if (done_run & (run_code_q == `FCSU_CMD_BLANK)) begin
            blank_q <= array_blank_ok;
        end else if (go) begin
            blank_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // staged command words and write order
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_q <= FCSU_SEQ_NONE;
        end else if (launch | acc_set) begin
            seq_q <= FCSU_SEQ_NONE;
        end else if (wr_cmd) begin
            seq_q <= FCSU_SEQ_CMD;
        end else if (wr_data) begin
            seq_q <= FCSU_SEQ_DATA;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_q <= `FCSU_RST_BYTE;
            data_q <= `FCSU_RST_BYTE;
            addr_q <= `FCSU_RST_ADDR;
        end else begin
            if (wr_cmd & ~seq_acc) begin
                code_q <= w_lo;
            end
            if (wr_data & ~seq_acc) begin
                data_q <= w_lo;
            end
            if (wr_addr_lo & cbef_q) begin
                addr_q[7:0] <= w_lo;
            end
            if (wr_addr_hi & cbef_q) begin
                addr_q[15:8] <= wdata_q[15:8];
            end
        end
    end

    // the divider value itself is only held and read back here; no output carries it to the array engine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q        <= `FCSU_RST_BYTE;
            div_loaded_q <= 1'b0;
        end else if (wr_div) begin
            div_q        <= w_lo;
            div_loaded_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // array requests
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q      <= '0;
            pend_q     <= '0;
            run_code_q <= `FCSU_RST_BYTE;
            start_q    <= 1'b0;
            abort_q    <= 1'b0;
            stop_q     <= 1'b0;
        end else begin
            stop_q  <= stop_mode;
            start_q <= start_new | done_pend;
            abort_q <= go_abort;
            if (start_new) begin
                req_q      <= new_req;
                run_code_q <= code_q;
            end else if (done_pend) begin
                req_q      <= pend_q;
                run_code_q <= pend_q.code;
            end
            if (queue_hold) begin
                pend_q <= new_req;
            end
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            aw_full_q <= (aw_full_q & ~wr_fire) | aw_take;
            w_full_q  <= (w_full_q & ~wr_fire) | w_take;
            awready_q <= ~((aw_full_q & ~wr_fire) | aw_take);
            wready_q  <= ~((w_full_q & ~wr_fire) | w_take);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `FCSU_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= w_mapped ? `FCSU_RESP_OKAY : `FCSU_RESP_SLVERR;
        end else if (b_done) begin
            bvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    wire [7:0] status_rd = {cbef_q, ccf_q, pviol_q, acc_q, 1'b0, blank_q, 2'b00};
    wire [31:0] rd_word  = sel_r_status ? {24'h00_0000, status_rd}
                         : sel_r_cmd    ? {24'h00_0000, code_q}
                         : sel_r_div    ? {23'h0, div_loaded_q, div_q}
                         : sel_r_addr   ? {16'h0000, addr_q}
                         : sel_r_data   ? {24'h00_0000, data_q}
                         : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `FCSU_RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= r_mapped ? `FCSU_RESP_OKAY : `FCSU_RESP_SLVERR;
        end else if (r_done) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign array_start   = start_q;
    assign array_req     = req_q;
    assign array_abort   = abort_q;
    assign staged_addr   = addr_q;

endmodule

//--- rtl/fcsu_map.svh
`ifndef FCSU_MAP_SVH
`define FCSU_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FCSU_OFF_STATUS   8'h00
`define FCSU_OFF_CMD      8'h04
`define FCSU_OFF_DIVIDER  8'h08
`define FCSU_OFF_ADDR     8'h0c
`define FCSU_OFF_DATA     8'h10

// ----------------------------------------------------------------
// status and divider bit positions
// ----------------------------------------------------------------
`define FCSU_BIT_CBEF     7
`define FCSU_BIT_CCF      6
`define FCSU_BIT_PVIOL    5
`define FCSU_BIT_ACCERR   4
`define FCSU_BIT_BLANK    2
`define FCSU_BIT_DIV_LOADED 8

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define FCSU_CMD_BLANK    8'h05
`define FCSU_CMD_BYTE     8'h20
`define FCSU_CMD_BURST    8'h25
`define FCSU_CMD_SECTOR   8'h40
`define FCSU_CMD_MASS     8'h41
`define FCSU_CMD_ABORT    8'h47

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define FCSU_RST_BYTE     8'h00
`define FCSU_RST_ADDR     16'h0000
`define FCSU_RESP_OKAY    2'b00
`define FCSU_RESP_SLVERR  2'b10

`endif

//--- rtl/fcsu_pkg.sv
package fcsu_pkg;

    typedef enum logic [1:0] {
        FCSU_IDLE  = 2'b00,
        FCSU_RUN   = 2'b01,
        FCSU_RUN_Q = 2'b11
    } fcsu_eng_type;

    typedef enum logic [1:0] {
        FCSU_SEQ_NONE = 2'b00,
        FCSU_SEQ_DATA = 2'b01,
        FCSU_SEQ_CMD  = 2'b11
    } fcsu_seq_type;

    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] addr;
        logic [7:0]  data;
    } fcsu_req_type;

endpackage

//--- tb/fcsu_array_model.sv
`timescale 1ns/1ps
module fcsu_array_model (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       array_start,
    input wire logic       array_abort,
    input wire logic [7:0] lat,
    input wire logic       erased,
    output logic           array_done,
    output logic           array_blank_ok
);
    // ----------------------------------------------------------------
    // array engine: one command at a time, done after lat cycles
    // ----------------------------------------------------------------
    logic [7:0] cnt_q;
    logic       tgl_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 8'h00;
            array_done <= 1'b0;
            tgl_q <= 1'b0;
        end else begin
            tgl_q <= ~tgl_q;
            array_done <= (cnt_q == 8'h01);
            if (array_start) cnt_q <= lat;
            else if (array_abort) cnt_q <= 8'h02; // abort cuts the erase short
            else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
        end
    end
    // result is only valid with done; elsewhere it wanders so stale use shows up
    assign array_blank_ok = array_done ? erased : tgl_q;
endmodule

//--- tb/fcsu_core_asserts.sv
`timescale 1ns/1ps
module fcsu_core_asserts (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic [7:0]            s_axi_araddr,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic                  array_start,
    input wire fcsu_pkg::fcsu_req_type array_req,
    input wire logic                  array_abort,
    input wire logic                  target_protected,
    input wire logic                  any_sector_protected
);
    import fcsu_pkg::*;
    // ----------------------------------------------------------------
    // checks on the status reads and the array command port
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [7:0] ra_q;
    // the read address is kept so that rdata can be tied to the status word
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
    end
    wire st_rd = s_axi_rvalid && (ra_q == 8'h00);
    property p_code_ok; array_start |-> array_req.code inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47}; endproperty
    a_code_ok: assert property (p_code_ok) else $error("array start with unknown code");
    property p_one_start; array_start |=> !array_start; endproperty
    a_one_start: assert property (p_one_start) else $error("array start longer than one cycle");
    property p_prot; array_start && array_req.code inside {8'h20, 8'h40} |-> !$past(target_protected); endproperty
    a_prot: assert property (p_prot) else $error("protected target was started");
    property p_mass; array_start && array_req.code == 8'h41 |-> !$past(any_sector_protected); endproperty
    a_mass: assert property (p_mass) else $error("mass erase started with a protected sector");
    property p_abort; array_abort |-> array_req.code == 8'h40 && !array_start; endproperty
    a_abort: assert property (p_abort) else $error("abort without a running sector erase");
    property p_unused; st_rd |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[3] == 1'b0 && s_axi_rdata[1:0] == 2'b00; endproperty
    a_unused: assert property (p_unused) else $error("unused status bit reads one");
    property p_blank; st_rd && s_axi_rdata[2] |-> s_axi_rdata[6]; endproperty
    a_blank: assert property (p_blank) else $error("blank flag set while busy");
    property p_rst; disable iff (1'b0) !aresetn |=> !array_start && !array_abort && !s_axi_rvalid; endproperty
    a_rst: assert property (p_rst) else $error("outputs active after reset");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped before rready");
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "fcsu_map.svh"
module tb_top;
    import fcsu_pkg::*;
    // ----------------------------------------------------------------
    // bench for the flash command and status unit
    // ----------------------------------------------------------------
    localparam logic [7:0] ST = `FCSU_OFF_STATUS;
    localparam logic [7:0] CM = `FCSU_OFF_CMD;
    localparam logic [7:0] DV = `FCSU_OFF_DIVIDER;
    localparam logic [7:0] DA = `FCSU_OFF_DATA;
    logic         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic         s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic         s_axi_rvalid, array_start, array_abort, array_done, array_blank_ok;
    logic         target_protected, any_sector_protected, stop_mode, erased;
    logic [1:0]   s_axi_bresp, s_axi_rresp, br, rr;
    logic [3:0]   s_axi_wstrb;
    logic [7:0]   s_axi_awaddr, s_axi_araddr, lat, c;
    logic [15:0]  staged_addr;
    logic [31:0]  s_axi_wdata, s_axi_rdata, rv, seed;
    fcsu_req_type array_req;
    int           n_mismatch, n_tests, n_st, n_ab, n;
    logic [7:0]   codes [7] = '{8'h05, 8'h20, 8'h40, 8'h41, 8'h47, 8'h25, 8'h05}; // blank check first with erased set, and last, after burst, with erased clear
    logic [7:0]   pcodes [4] = '{8'h20, 8'h25, 8'h40, 8'h41};
    fcsu_core uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .array_start, .array_req, .array_abort, .array_done, .array_blank_ok,
        .staged_addr, .target_protected, .any_sector_protected, .stop_mode);
    fcsu_array_model u_arr (.aclk, .aresetn, .array_start, .array_abort, .lat, .erased,
        .array_done, .array_blank_ok);
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (array_start) n_st++;
        if (array_abort) n_ab++;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic legal(input logic [7:0] k);
        return k inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47};
    endfunction
    function automatic logic [31:0] st_exp(input logic [7:0] k, input logic e);
        return (k == 8'h05 && e) ? 32'hc4 : 32'hc0;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (s_axi_awready) aw = 1'b0;
            if (s_axi_wready) w = 1'b0;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        while (!s_axi_bvalid) @(posedge aclk);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // rready is raised a cycle late so the slave has to hold its answer
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic sts(input logic [31:0] e);
        rd(ST);
        chk(rv, e);
    endtask
    task automatic launch(input logic [7:0] k);
        wr(DA, xs() & 32'hff);
        wr(CM, {24'h0, k});
        wr(ST, 32'h80);
    endtask
    // blank result is only read once complete is seen
    task automatic idle();
        rd(ST);
        for (int i = 0; i < 40 && !rv[6]; i++) rd(ST);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {target_protected, any_sector_protected, stop_mode, erased} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        lat = 8'd30;
        seed = 32'd49;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        sts(32'hc0);
        launch(8'h20);
        sts(32'hd0);
        chk(n_st, 0);
        wr(ST, 32'h4f);
        sts(32'hd0);
        wr(ST, 32'h10);
        sts(32'hc0);
        wr(DV, 32'h0a);
        rd(DV);
        chk(rv, 32'h10a);
        wr(`FCSU_OFF_ADDR, 32'h0000_a5c3);
        chk(staged_addr, 32'ha5c3);
        $display("test flags done");
        foreach (codes[i]) begin
            c = codes[i];
            erased <= (i == 0);
            lat <= 8'(xs() % 16) + 8'd24;
            n = n_st;
            launch(c);
            rd(ST);
            chk(rv[6], 1'b0);
            idle();
            chk(n_st, n + 1);
            chk(array_req.code, c);
            chk(array_req.addr, 32'ha5c3);
            chk(rv, st_exp(c, i == 0));
        end
        $display("test codes done");
        repeat (4) begin
            c = 8'(xs());
            if (legal(c)) c = c ^ 8'h80;
            n = n_st;
            launch(c);
            sts(32'hd0);
            chk(n_st, n);
            wr(ST, 32'h10);
        end
        wr(CM, 32'h20);
        wr(ST, 32'h80);
        sts(32'hd0);
        wr(ST, 32'h10);
        $display("test errors done");
        foreach (pcodes[i]) begin
            target_protected <= (i != 3);
            any_sector_protected <= (i == 3);
            n = n_st;
            launch(pcodes[i]);
            wr(ST, 32'h00);
            sts(32'he0);
            chk(n_st, n);
            wr(ST, 32'h20);
            sts(32'hc0);
        end
        {target_protected, any_sector_protected} <= 2'b00;
        $display("test protect done");
        lat <= 8'd60;
        n = n_st;
        launch(8'h25);
        launch(8'h25);
        rd(ST);
        chk(rv[7:6], 2'b00);
        idle();
        chk(n_st, n + 2);
        chk(rv, 32'hc0);
        n = n_ab;
        launch(8'h40);
        launch(8'h47);
        idle();
        chk(n_ab, n + 1);
        chk(rv, 32'hc0);
        n = n_st;
        launch(8'h25);
        launch(8'h25);
        stop_mode <= 1'b1;
        idle();
        chk(rv, 32'hd0);
        chk(n_st, n + 1);
        stop_mode <= 1'b0;
        wr(ST, 32'h10);
        $display("test queue done");
        wr(8'h20, 32'h5a);
        chk(br, 2'b10);
        rd(8'h20);
        chk(rr, 2'b10);
        chk(rv, 32'h0);
        $display("test unmapped done");
        stop_test();
    end
    initial begin
        #80000;
        n_mismatch++;
        stop_test();
    end
endmodule
bind fcsu_core fcsu_core_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .array_start(array_start),
    .array_req(array_req), .array_abort(array_abort), .target_protected(target_protected),
    .any_sector_protected(any_sector_protected));
